/* gpt_timer.sv */
// general purpose timer: counter, prescaler, channels, AHB-Lite registers
`timescale 1ns/100ps
module gpt_timer import gpt_pkg::*; #(
    parameter int CNT_W    = 32,
    parameter int PSC_W    = 16,
    parameter int NUM_CH   = 4,
    parameter int NUM_COMP = 0,
    parameter bit HAS_DOWN = 1'b1,
    parameter bit HAS_ENC  = 1'b1,
    parameter bit HAS_DMA  = 1'b1,
    parameter int CHP      = (NUM_CH > 0) ? NUM_CH : 1,
    parameter int CPP      = (NUM_COMP > 0) ? NUM_COMP : 1
)(
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output wire logic              hreadyout,
    output wire logic [31:0]       hrdata,
    output wire logic              hresp,
    input  wire logic [CHP-1:0]    capIn,
    output wire logic [CHP-1:0]    chOut,
    output wire logic [CHP-1:0]    chOutEn,
    output wire logic [CPP-1:0]    compOut,
    output wire logic [CPP-1:0]    compOutEn,
    input  wire logic              encA,
    input  wire logic              encB,
    input  wire logic              trigIn,
    output wire logic              trigOut,
    input  wire logic              dbgHalt,
    output wire logic              irq,
    output wire logic [EVT_W-1:0]  dmaReq
);

    // ==========================================================
    // bus slave
    gpt_ahb_req_t     dpReq_q;
    logic [31:0]      hrdata_q;
    logic [CNT_W-1:0] ccrArr [MAX_CH];

    wire addrTaken = hsel & hready & htrans[HTRANS_ACT];
    wire wrPhase   = dpReq_q.valid & dpReq_q.write;
    wire [5:0] ra  = haddr[5:0];
    wire [5:0] wa  = dpReq_q.addr;

    wire wrCtrl   = wrPhase & (wa == OFF_CTRL);
    wire wrClear  = wrPhase & (wa == OFF_CLEAR);
    wire wrIrqEn  = wrPhase & (wa == OFF_IRQEN);
    wire wrDmaEn  = wrPhase & (wa == OFF_DMAEN);
    wire wrCnt    = wrPhase & (wa == OFF_CNT);
    wire wrPsc    = wrPhase & (wa == OFF_PSC);
    wire wrArr    = wrPhase & (wa == OFF_ARR);
    wire wrCcMode = wrPhase & (wa == OFF_CCMODE);
    wire wrCompEn = wrPhase & (wa == OFF_COMPEN);
    wire wrCcrAny = wrPhase & (wa[5:4] == OFF_CCR0[5:4]);

    // ==========================================================
    // control and status registers
    gpt_ctrl_t        ctrl_q;
    logic [EVT_W-1:0] status_q;
    logic [EVT_W-1:0] irqEn_q;
    logic [EVT_W-1:0] dmaEn_q;
    logic [CNT_W-1:0] cnt_q;
    logic [PSC_W-1:0] psc_q;
    logic [CNT_W-1:0] arr_q;
    logic [15:0]      ccMode_q;
    logic [MAX_CH-1:0] compEn_q;
    logic             downPhase_q;
    logic             trigPrev_q;
    logic [1:0]       encPrev_q;

    wire gpt_ctrl_t ctrlWr = gpt_ctrl_t'(hwdata[CTRL_W-1:0]);

    // unmapped offsets read as zero and ignore writes
    wire [31:0] rdVal =
        (ra == OFF_CTRL)   ? 32'(ctrl_q)   :
        (ra == OFF_STATUS) ? 32'(status_q) :
        (ra == OFF_IRQEN)  ? 32'(irqEn_q)  :
        (ra == OFF_DMAEN)  ? 32'(dmaEn_q)  :
        (ra == OFF_CNT)    ? 32'(cnt_q)    :
        (ra == OFF_PSC)    ? 32'(psc_q)    :
        (ra == OFF_ARR)    ? 32'(arr_q)    :
        (ra == OFF_CCMODE) ? 32'(ccMode_q) :
        (ra == OFF_COMPEN) ? 32'(compEn_q) :
        (ra[5:4] == OFF_CCR0[5:4]) ? 32'(ccrArr[ra[3:2]]) : RD_ZERO;

    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_q;

    // ==========================================================
    // counting source
    wire trigRise = trigIn & ~trigPrev_q;
    wire encMode  = HAS_ENC & ctrl_q.encoder;
    wire extClk   = (ctrl_q.slave == SLV_EXTCLK);
    wire trigRst  = (ctrl_q.slave == SLV_RESET) & trigRise;
    wire gateOk   = (ctrl_q.slave != SLV_GATED) | trigIn;
    wire frozen   = ctrl_q.freeze & dbgHalt;
    wire run      = ctrl_q.enable & ~frozen & gateOk;
    wire pscRun   = run & ~extClk & ~encMode;
    wire pscTick;

    // x4 quadrature decode; a double transition counts once
    wire encStep  = ((encA ^ encPrev_q[1]) | (encB ^ encPrev_q[0]));
    wire encUp    = ~(encPrev_q[1] ^ encB);

    wire step = encMode ? (run & encStep) :
                extClk  ? (run & trigRise) : pscTick;

    gpt_prescaler #(
        .W       (PSC_W)
    ) u_psc (
        .mclk    (mclk),
        .reset   (reset),
        .run     (pscRun),
        .restart (trigRst),
        .div     (psc_q),
        .tick    (pscTick)
    );

    // ==========================================================
    // counter core
    // up-only variants ignore direction and center programming
    wire gpt_dir_t dirMode = HAS_DOWN ? ctrl_q.dir : DIR_UP;
    wire centerMode = (dirMode == DIR_CENTER) & ~encMode;
    wire countUp = encMode ? encUp :
                   ~((dirMode == DIR_DOWN) | (centerMode & downPhase_q));
    wire atTop  = (cnt_q == arr_q);
    wire atBot  = (cnt_q == '0);
    wire wrapUp = step & countUp & atTop;
    wire wrapDn = step & ~countUp & atBot;
    wire updEvt = wrapUp | wrapDn;

    wire [CNT_W-1:0] cntInc = cnt_q + 1'b1;
    wire [CNT_W-1:0] cntDec = cnt_q - 1'b1;
    wire [CNT_W-1:0] cntStep =
        // center mode turns at both ends: down at the top, up at the bottom
        centerMode ? (((countUp & ~atTop) | (~countUp & atBot)) ? cntInc : cntDec) :
        countUp    ? (atTop ? '0 : cntInc) :
                     (atBot ? arr_q : cntDec);
    wire [CNT_W-1:0] cnt_d =
        wrCnt   ? hwdata[CNT_W-1:0] :
        trigRst ? '0 :
        step    ? cntStep : cnt_q;

    wire downPhase_d = centerMode & (wrapUp | (downPhase_q & ~wrapDn));
    // one-pulse stops at the update, a reset trigger restarts
    wire enable_d = wrCtrl  ? ctrlWr.enable :
                    trigRst ? 1'b1 :
                    (updEvt & ctrl_q.onePulse) ? 1'b0 : ctrl_q.enable;

    // ==========================================================
    // channels
    logic [MAX_CH-1:0] chLvl;
    logic [MAX_CH-1:0] chEvt;
    logic [MAX_CH-1:0] chDrive;

    for (genvar i = 0; i < MAX_CH; i++) begin : g_ch
        if (i < NUM_CH) begin : g_on
            wire gpt_chmode_t m = gpt_chmode_t'(ccMode_q[CCM_W*i +: 2]);
            wire wrThis = wrCcrAny & (wa[3:2] == 2'(i));
            gpt_channel #(
                .W        (CNT_W)
            ) u_ch (
                .mclk     (mclk),
                .reset    (reset),
                .cnt      (cnt_q),
                .mode     (m),
                .invert   (ccMode_q[CCM_W*i + CCM_INV]),
                .capIn    (capIn[i]),
                .wrEn     (wrThis),
                .wrData   (hwdata[CNT_W-1:0]),
                .ccr      (ccrArr[i]),
                .chOut    (chLvl[i]),
                .evtPulse (chEvt[i])
            );
            assign chDrive[i] = ccMode_q[CCM_W*i + CCM_OE] & (m != CH_CAPTURE);
        end else begin : g_off
            // channels at or above NUM_CH leave these at zero
            assign ccrArr[i]  = '0;
            assign chLvl[i]   = 1'b0;
            assign chEvt[i]   = 1'b0;
            assign chDrive[i] = 1'b0;
        end
    end

    assign chOut   = chLvl[CHP-1:0];
    assign chOutEn = chDrive[CHP-1:0];
    // complementary pins follow the inverse of the paired channel
    assign compOut   = (NUM_COMP > 0) ?
                       (~chLvl[CPP-1:0] & compEn_q[CPP-1:0]) : '0;
    assign compOutEn = (NUM_COMP > 0) ? compEn_q[CPP-1:0] : '0;

    // ==========================================================
    // events, interrupt, DMA, trigger out
    wire [EVT_W-1:0] evt      = {chEvt, updEvt};
    wire [EVT_W-1:0] clrMask  = wrClear ? hwdata[EVT_W-1:0] : '0;
    // a new event wins over a clear in the same cycle
    wire [EVT_W-1:0] status_d = (status_q & ~clrMask) | evt;

    assign irq     = |(status_q & irqEn_q);
    assign dmaReq  = HAS_DMA ? (evt & dmaEn_q) : '0;
    // update pulse feeds converters and other timers
    assign trigOut = updEvt;

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            dpReq_q  <= '0;
            hrdata_q <= '0;
        end else begin
            dpReq_q  <= '{valid: addrTaken, write: hwrite, addr: ra};
            hrdata_q <= (addrTaken & ~hwrite) ? rdVal : hrdata_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_q   <= '0;
            irqEn_q  <= '0;
            dmaEn_q  <= '0;
            psc_q    <= '0;
            arr_q    <= {CNT_W{ARR_RST}};
            ccMode_q <= '0;
            compEn_q <= '0;
        end else begin
            ctrl_q        <= wrCtrl ? ctrlWr : ctrl_q;
            ctrl_q.enable <= enable_d;
            irqEn_q       <= wrIrqEn ? hwdata[EVT_W-1:0] : irqEn_q;
            dmaEn_q       <= wrDmaEn ? hwdata[EVT_W-1:0] : dmaEn_q;
            psc_q         <= wrPsc ? hwdata[PSC_W-1:0] : psc_q;
            arr_q         <= wrArr ? hwdata[CNT_W-1:0] : arr_q;
            ccMode_q      <= wrCcMode ? hwdata[15:0] : ccMode_q;
            compEn_q      <= wrCompEn ? hwdata[MAX_CH-1:0] : compEn_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_q       <= '0;
            status_q    <= '0;
            downPhase_q <= 1'b0;
            trigPrev_q  <= 1'b0;
            encPrev_q   <= '0;
        end else begin
            cnt_q       <= cnt_d;
            status_q    <= status_d;
            downPhase_q <= downPhase_d;
            trigPrev_q  <= trigIn;
            encPrev_q   <= {encA, encB};
        end
    end

    // ==========================================================
    // checks
    sequence s_upTop;
        step && countUp && atTop && !wrCnt && !trigRst && !centerMode;
    endsequence

    sequence s_dnBot;
        step && !countUp && atBot && !wrCnt && !trigRst && !centerMode;
    endsequence

    a_up_reload: assert property (@(posedge mclk) disable iff (reset)
        s_upTop |=> cnt_q == '0 && status_q[ST_UPD])
        else $error("up wrap did not reload zero");

    a_down_reload: assert property (@(posedge mclk) disable iff (reset)
        s_dnBot |=> cnt_q == $past(arr_q) && status_q[ST_UPD])
        else $error("down wrap did not reload from arr");

    a_freeze_hold: assert property (@(posedge mclk) disable iff (reset)
        frozen && !wrCnt && !trigRst |=> $stable(cnt_q))
        else $error("counter moved while frozen");

    a_onepulse_stop: assert property (@(posedge mclk) disable iff (reset)
        updEvt && ctrl_q.onePulse && !wrCtrl && !trigRst |=> !ctrl_q.enable ##1 !updEvt)
        else $error("one-pulse did not stop");

    a_set_wins: assert property (@(posedge mclk) disable iff (reset)
        (evt & clrMask) != '0 |=> (status_q & $past(evt & clrMask)) == $past(evt & clrMask))
        else $error("event lost under clear");

    a_irq_level: assert property (@(posedge mclk) disable iff (reset)
        updEvt && irqEn_q[ST_UPD] && !wrIrqEn |=> irq)
        else $error("update did not raise interrupt");

    a_dma_pulse: assert property (@(posedge mclk) disable iff (reset)
        HAS_DMA && updEvt && dmaEn_q[ST_UPD] |-> dmaReq[ST_UPD] && trigOut)
        else $error("update dma request missing");

    a_up_only: assert property (@(posedge mclk) disable iff (reset)
        !HAS_DOWN && !encMode && step && !atTop && !wrCnt && !trigRst
        |=> cnt_q == $past(cntInc))
        else $error("up-only variant did not count up");

    a_read_data: assert property (@(posedge mclk) disable iff (reset)
        addrTaken && !hwrite |=> hrdata == $past(rdVal))
        else $error("read data not presented in data phase");

endmodule

/* gpt_pkg.sv */
// shared constants, register map and carrier types of the timer
package gpt_pkg;

    // ==========================================================
    // register byte offsets (one 32-bit word each)
    localparam logic [5:0] OFF_CTRL   = 6'h00;
    localparam logic [5:0] OFF_STATUS = 6'h04;
    localparam logic [5:0] OFF_CLEAR  = 6'h08;
    localparam logic [5:0] OFF_IRQEN  = 6'h0c;
    localparam logic [5:0] OFF_DMAEN  = 6'h10;
    localparam logic [5:0] OFF_CNT    = 6'h14;
    localparam logic [5:0] OFF_PSC    = 6'h18;
    localparam logic [5:0] OFF_ARR    = 6'h1c;
    localparam logic [5:0] OFF_CCMODE = 6'h20;
    localparam logic [5:0] OFF_COMPEN = 6'h24;
    localparam logic [5:0] OFF_CCR0   = 6'h30;

    // ==========================================================
    // field layout and reset values
    localparam int         MAX_CH     = 4;
    localparam int         EVT_W      = MAX_CH + 1;
    localparam int         ST_UPD     = 0;
    localparam int         ST_CH0     = 1;
    localparam int         CCM_W      = 4;
    localparam int         CCM_INV    = 2;
    localparam int         CCM_OE     = 3;
    localparam int         CTRL_W     = 8;
    localparam int         HTRANS_ACT = 1;
    localparam logic       ARR_RST    = 1'b1;
    localparam logic       HRESP_OKAY = 1'b0;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

    // ==========================================================
    // modes
    typedef enum logic [1:0] {DIR_UP, DIR_DOWN, DIR_CENTER, DIR_RSVD} gpt_dir_t;
    typedef enum logic [1:0] {SLV_OFF, SLV_RESET, SLV_GATED, SLV_EXTCLK} gpt_slave_t;
    typedef enum logic [1:0] {CH_CAPTURE, CH_TOGGLE, CH_PWM, CH_FROZEN} gpt_chmode_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       encoder;
        gpt_slave_t slave;
        logic       freeze;
        logic       onePulse;
        gpt_dir_t   dir;
        logic       enable;
    } gpt_ctrl_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [5:0] addr;
    } gpt_ahb_req_t;

endpackage

/* gpt_prescaler.sv */
// clock prescaler: one tick every div+1 enabled cycles
`timescale 1ns/100ps
module gpt_prescaler import gpt_pkg::*; #(
    parameter int W = 16
)(
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic         run,
    input  wire logic         restart,
    input  wire logic [W-1:0] div,
    output wire logic         tick
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    // >= rather than == so that shrinking div never strands the count
    assign tick    = run & ~restart & (count_q >= div);
    assign count_d = (restart | tick) ? '0 : run ? count_q + 1'b1 : count_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    a_tick_spacing: assert property (@(posedge mclk) disable iff (reset)
        tick && div != '0 && $stable(div) |=> !tick)
        else $error("prescaler ticked twice in a row");
endmodule

/* gpt_channel.sv */
// one capture/compare channel with its compare register
`timescale 1ns/100ps
module gpt_channel import gpt_pkg::*; #(
    parameter int W = 32
)(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [W-1:0] cnt,
    input  wire gpt_chmode_t mode,
    input  wire logic        invert,
    input  wire logic        capIn,
    input  wire logic        wrEn,
    input  wire logic [W-1:0] wrData,
    output wire logic [W-1:0] ccr,
    output wire logic        chOut,
    output wire logic        evtPulse
);
    logic         capPrev_q;
    logic         match_q;
    logic         out_q;
    logic         out_d;
    logic [W-1:0] ccr_q;
    logic [W-1:0] ccr_d;

    // invert selects the falling edge in capture mode
    wire capEdge  = invert ? (capPrev_q & ~capIn) : (~capPrev_q & capIn);
    wire isCap    = (mode == CH_CAPTURE);
    wire capHit   = isCap & capEdge;
    wire matchNow = (cnt == ccr_q);
    wire matchHit = ~isCap & matchNow & ~match_q;
    wire pwmLvl   = (cnt < ccr_q) ^ invert;

    assign evtPulse = capHit | matchHit;
    // a capture beats a software write in the same cycle
    assign ccr_d    = capHit ? cnt : wrEn ? wrData : ccr_q;
    assign out_d    = (mode == CH_PWM)    ? pwmLvl :
                      (mode == CH_TOGGLE) ? (out_q ^ matchHit) : invert;
    assign ccr      = ccr_q;
    assign chOut    = out_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            capPrev_q <= 1'b0;
            match_q   <= 1'b0;
            out_q     <= 1'b0;
            ccr_q     <= '0;
        end else begin
            capPrev_q <= capIn;
            match_q   <= matchNow;
            out_q     <= out_d;
            ccr_q     <= ccr_d;
        end
    end

    a_capture_latch: assert property (@(posedge mclk) disable iff (reset)
        capHit |=> ccr == $past(cnt) && !evtPulse)
        else $error("capture did not latch the counter");

    a_pwm_level: assert property (@(posedge mclk) disable iff (reset)
        mode == CH_PWM && $stable(mode) |=> chOut == $past(pwmLvl))
        else $error("pwm output does not follow compare");
endmodule

/* gpt_pin_model.sv */
// pin-side partner model: capture pulses, quadrature encoder and link trigger
`timescale 1ns/100ps
module gpt_pin_model #(
    parameter int CHP = 4
)(
    input  wire logic           mclk,
    output logic     [CHP-1:0]  capIn,
    output logic                encA,
    output logic                encB,
    output logic                trigIn
);
    logic [1:0] phase = 2'h0;

    initial begin
        capIn  = '0;
        encA   = 1'b0;
        encB   = 1'b0;
        trigIn = 1'b0;
    end

    // ==========================================================
    // capture edge, held two cycles so a sync sampler cannot miss it
    task automatic capture(input int ch);
        @(posedge mclk) capIn[ch] <= 1'b1;
        repeat (2) @(posedge mclk);
        capIn[ch] <= 1'b0;
    endtask

    // ==========================================================
    // gray sequence 00,10,11,01 forward; one step every two cycles
    task automatic enc(input int steps, input bit fwd);
        for (int i = 0; i < steps; i++) begin
            repeat (2) @(posedge mclk);
            phase = fwd ? phase + 2'h1 : phase - 2'h1;
            encA <= (phase == 2'h1) || (phase == 2'h2);
            encB <= phase[1];
        end
    endtask

    // ==========================================================
    // link pulse from a neighbouring timer
    task automatic trig();
        @(posedge mclk) trigIn <= 1'b1;
        repeat (2) @(posedge mclk);
        trigIn <= 1'b0;
    endtask
endmodule

/* tb_top.sv */
// self-checking bench for the timer
`timescale 1ns/100ps
module tb_top import gpt_pkg::*;;
    typedef struct {logic [5:0] a; logic [31:0] w; logic [31:0] e;} gpt_row_t;
    typedef struct {logic [31:0] c; logic [31:0] p; logic [31:0] r; int g;} gpt_per_t;

    logic             mclk = 1'b0;
    logic             reset = 1'b1;
    logic             hsel = 1'b0;
    logic             hwrite = 1'b0;
    logic             dbgHalt = 1'b0;
    logic [31:0]      haddr = '0;
    logic [31:0]      hwdata = '0;
    logic [1:0]       htrans = 2'h0;
    logic [2:0]       hsize = 3'h2;
    wire              hreadyout, hresp, irq, trigOut, encA, encB, trigIn;
    wire [31:0]       hrdata;
    wire [3:0]        capIn, chOut, chOutEn;
    wire [0:0]        compOut, compOutEn;
    wire [EVT_W-1:0]  dmaReq;
    int               fails = 0;
    int               cmp_count = 0;
    int               n, d;
    logic [31:0]      rd, c1;

    gpt_row_t rows[11] = '{
        '{OFF_CTRL, 32'h0000_0010, 32'h0000_0010}, '{OFF_IRQEN, 32'h0000_001f, 32'h0000_001f},
        '{OFF_DMAEN, 32'h0000_001f, 32'h0000_001f}, '{OFF_PSC, 32'hffff_ffff, 32'h0000_ffff},
        '{OFF_ARR, 32'h1234_5678, 32'h1234_5678}, '{OFF_CCMODE, 32'h0000_3210, 32'h0000_3210},
        '{OFF_CCR0, 32'hdead_beef, 32'hdead_beef}, '{6'h3c, 32'h0000_0001, 32'h0000_0001},
        '{6'h28, 32'h0000_ffff, 32'h0000_0000}, '{OFF_CLEAR, 32'h0000_001f, 32'h0000_0000},
        '{OFF_STATUS, 32'h0000_001f, 32'h0000_0000}};
    // ctrl: 01 up, 03 down, 05 centre
    gpt_per_t pers[4] = '{'{32'h01, 32'h0, 32'h4, 5}, '{32'h01, 32'h2, 32'h1, 6},
                          '{32'h03, 32'h0, 32'h3, 4}, '{32'h05, 32'h0, 32'h3, 3}};

    always #20 mclk = ~mclk;

    gpt_timer gpt_timer_i (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .capIn(capIn), .chOut(chOut),
        .chOutEn(chOutEn), .compOut(compOut), .compOutEn(compOutEn), .encA(encA), .encB(encB),
        .trigIn(trigIn), .trigOut(trigOut), .dbgHalt(dbgHalt), .irq(irq), .dmaReq(dmaReq));

    gpt_pin_model #(.CHP(4)) gpt_pin_model_i (.mclk(mclk), .capIn(capIn), .encA(encA),
        .encB(encB), .trigIn(trigIn));

    // ==========================================================
    // bus and compare tasks
    task automatic ahb(input logic wr, input logic [5:0] a, input logic [31:0] w);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {26'h0, a};
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic gap();
        n = 0;
        d = 0;
        for (int i = 0; i < 300 && trigOut !== 1'b1; i++) @(negedge mclk);
        do begin
            @(negedge mclk);
            n++;
            if (dmaReq[0] === 1'b1) d++;
        end while (trigOut !== 1'b1 && n < 300);
    endtask

    task automatic finish_test();
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #(40 * 30000);
        fails++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        ahb(1'b0, OFF_ARR, '0);
        chk(rd, 32'hffff_ffff, "arr reset");
        ahb(1'b0, OFF_CTRL, '0);
        chk(rd, 32'h0, "ctrl reset");
        chk({hresp, compOut, compOutEn, irq, chOutEn}, 8'h0, "outputs reset");
        foreach (rows[i]) begin
            ahb(1'b1, rows[i].a, rows[i].w);
            ahb(1'b0, rows[i].a, '0);
            chk(rd, rows[i].e, "register row");
        end
        ahb(1'b1, OFF_IRQEN, 32'h0);
        ahb(1'b1, OFF_DMAEN, 32'h1);
        ahb(1'b1, OFF_CCMODE, 32'h0);
        foreach (pers[i]) begin
            ahb(1'b1, OFF_CTRL, 32'h0);
            ahb(1'b1, OFF_CNT, 32'h0);
            ahb(1'b1, OFF_PSC, pers[i].p);
            ahb(1'b1, OFF_ARR, pers[i].r);
            ahb(1'b1, OFF_CTRL, pers[i].c);
            gap();
            gap();
            chk(n, pers[i].g, "update spacing");
            chk(d, 1, "dma with update");
        end
        // one update raises irq; mask and clear drop it
        ahb(1'b1, OFF_CTRL, 32'h0);
        ahb(1'b1, OFF_CLEAR, 32'h1f);
        ahb(1'b1, OFF_IRQEN, 32'h1);
        ahb(1'b1, OFF_CTRL, 32'h9);
        repeat (30) @(posedge mclk);
        ahb(1'b0, OFF_CTRL, '0);
        chk(rd[0], 1'b0, "one pulse stops");
        ahb(1'b0, OFF_STATUS, '0);
        chk(rd[0], 1'b1, "update flag");
        chk(irq, 1'b1, "irq set");
        ahb(1'b1, OFF_IRQEN, 32'h0);
        @(negedge mclk);
        chk(irq, 1'b0, "irq masked");
        ahb(1'b1, OFF_IRQEN, 32'h1);
        ahb(1'b1, OFF_CLEAR, 32'h1);
        @(negedge mclk);
        chk(irq, 1'b0, "irq cleared");
        // capture latches a held count
        ahb(1'b1, OFF_CNT, 32'h123);
        gpt_pin_model_i.capture(0);
        repeat (4) @(posedge mclk);
        ahb(1'b0, OFF_CCR0, '0);
        chk(rd, 32'h123, "capture value");
        ahb(1'b0, OFF_STATUS, '0);
        chk(rd[1], 1'b1, "capture flag");
        // debug freeze holds the count
        ahb(1'b1, OFF_ARR, 32'hffff);
        ahb(1'b1, OFF_CNT, 32'h0);
        dbgHalt <= 1'b1;
        ahb(1'b1, OFF_CTRL, 32'h11);
        repeat (10) @(posedge mclk);
        ahb(1'b0, OFF_CNT, '0);
        chk(rd, 32'h0, "frozen count");
        dbgHalt <= 1'b0;
        repeat (10) @(posedge mclk);
        ahb(1'b0, OFF_CNT, '0);
        chk(rd != 32'h0, 1'b1, "thawed count");
        // encoder forward then back returns to start
        ahb(1'b1, OFF_CTRL, 32'h0);
        ahb(1'b1, OFF_CNT, 32'h10);
        ahb(1'b1, OFF_CTRL, 32'h81);
        gpt_pin_model_i.enc(4, 1'b1);
        repeat (3) @(posedge mclk);
        ahb(1'b0, OFF_CNT, '0);
        c1 = rd;
        chk(c1 > 32'h10, 1'b1, "encoder forward");
        gpt_pin_model_i.enc(4, 1'b0);
        repeat (3) @(posedge mclk);
        ahb(1'b0, OFF_CNT, '0);
        chk(rd, 32'h10, "encoder back");
        // link trigger starts a stopped timer
        ahb(1'b1, OFF_CTRL, 32'h20);
        gpt_pin_model_i.trig();
        repeat (3) @(posedge mclk);
        ahb(1'b0, OFF_CTRL, '0);
        chk(rd[0], 1'b1, "trigger start");
        // held count: ch0 pwm, ch1 toggles on a fresh match
        ahb(1'b1, OFF_CTRL, 32'h0);
        ahb(1'b1, OFF_CNT, 32'h5);
        ahb(1'b1, OFF_CCMODE, 32'h9a);
        ahb(1'b1, 6'h34, 32'h5);
        ahb(1'b0, OFF_STATUS, '0);
        chk(rd[2], 1'b1, "compare event flag");
        @(negedge mclk);
        chk({chOutEn, chOut}, 8'h33, "pwm and toggle levels");
        ahb(1'b1, OFF_CCR0, 32'h3);
        repeat (2) @(negedge mclk);
        chk(chOut, 4'h2, "pwm low above compare");
        finish_test();
    end
endmodule
